// ===== rre_pkg.sv
package rre_pkg;
  // ---------------------------------------------------------------
  // instruction word (14-bit core encoding)
  // ---------------------------------------------------------------
  localparam int          INSN_W      = 14;
  localparam int          DATA_W      = 8;
  localparam int          FADDR_W     = 7;
  localparam int          PC_W        = 13;
  // return with literal: 11 01xx kkkk kkkk
  localparam logic [13:0] LITRET_MASK = 14'h3c00;
  localparam logic [13:0] LITRET_CODE = 14'h3400;
  // plain return
  localparam logic [13:0] RET_CODE    = 14'h0008;
  // rotate left: 00 1101 dfff ffff
  localparam logic [13:0] ROTL_MASK   = 14'h3f00;
  localparam logic [13:0] ROTL_CODE   = 14'h0d00;
  localparam int          DEST_BIT    = 7;
  localparam int          MSB_BIT     = 7;
  // ---------------------------------------------------------------
  // cycle counts and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  RET_CYCLES  = 2'h2;
  localparam logic [7:0]  W_RST       = 8'h00;
  localparam logic [12:0] PC_RST      = 13'h0000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FLUSH = 3'b010,
    ST_HOLD  = 3'b100
  } rre_state_t;
endpackage : rre_pkg

// ===== rre_if.sv
`timescale 1ns/1ps
interface rre_if;
  logic       is_litret;
  logic       is_ret;
  logic       is_rotl;
  logic [7:0] literal;
  logic [6:0] faddr;
  logic       dest_file;
  modport dec (output is_litret, is_ret, is_rotl, literal, faddr, dest_file);
  modport exe (input  is_litret, is_ret, is_rotl, literal, faddr, dest_file);
endinterface : rre_if

// ===== rre_decode.sv
`timescale 1ns/1ps
module rre_decode (
  // instruction
  input  wire logic [13:0] i_insn,
  input  wire logic        i_valid,
  // decoded fields
  rre_if.dec               dec
);
  always_comb begin
    dec.is_litret = i_valid && ((i_insn & rre_pkg::LITRET_MASK) == rre_pkg::LITRET_CODE);
    dec.is_ret    = i_valid && (i_insn == rre_pkg::RET_CODE);
    dec.is_rotl   = i_valid && ((i_insn & rre_pkg::ROTL_MASK) == rre_pkg::ROTL_CODE);
    dec.literal   = i_insn[7:0];
    dec.faddr     = i_insn[6:0];
    dec.dest_file = i_insn[rre_pkg::DEST_BIT];
  end
endmodule : rre_decode

// ===== rre_exec.sv
// Summary of operation
// RQ1: literal return writes 8-bit immediate to accumulator, flags untouched.
// RQ2: literal return loads program counter from stack top entry.
// RQ3: literal return is one word, two cycles, resumes at popped address.
// RQ4: plain return pops stack into program counter, no flags changed.
// RQ5: plain return takes two cycles due to redirect.
// RQ6: rotate left through carry, only carry flag changes.
// RQ7: rotate result to accumulator when dest bit 0, else to register.
// RQ8: old carry enters bit 0, old bit 7 becomes carry; one cycle.
`timescale 1ns/1ps
module rre_exec (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // instruction in
  input  wire logic [13:0] i_insn,
  input  wire logic        i_insn_valid,
  // core state in
  input  wire logic [12:0] i_stack_top_entry,
  input  wire logic [7:0]  i_file_rdata,
  input  wire logic [7:0]  i_w,
  input  wire logic        i_carry,
  // core state out
  output logic      [7:0]  o_w,
  output logic             o_w_we,
  output logic             o_carry,
  output logic             o_carry_we,
  output logic      [12:0] o_pc,
  output logic             o_pc_load,
  output logic             o_stack_pop,
  output logic      [6:0]  o_file_addr,
  output logic      [7:0]  o_file_wdata,
  output logic             o_file_we,
  output logic             o_busy
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  rre_if dif ();

  rre_decode u_dec (
    .i_insn  (i_insn),
    .i_valid (i_insn_valid),
    .dec     (dif)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  rre_pkg::rre_state_t state_reg, state_next;
  logic [7:0]  w_reg, w_next;
  logic        w_we_reg, w_we_next;
  logic        c_reg, c_next;
  logic        c_we_reg, c_we_next;
  logic [12:0] pc_reg, pc_next;
  logic        pcl_reg, pcl_next;
  logic        pop_reg, pop_next;
  logic [6:0]  fa_reg, fa_next;
  logic [7:0]  fd_reg, fd_next;
  logic        fwe_reg, fwe_next;
  logic        busy_reg, busy_next;
  logic [1:0]  cyc_reg, cyc_next;
  logic        idle;
  logic        take_ret;
  logic        take_rotl;
  logic [8:0]  rot;

  // bit 8 is the carry out, bits 7:0 the rotated value
  function automatic logic [8:0] rotl(input logic [7:0] v, input logic c);
    rotl = {v, c}; // see RQ8
  endfunction : rotl

  // ---------------------------------------------------------------
  // issue qualification
  // ---------------------------------------------------------------
  // words offered outside idle are dropped silently: the core has
  // already thrown them away as the flushed prefetch
  always_comb begin
    idle      = (state_reg == rre_pkg::ST_IDLE);
    take_ret  = idle && (dif.is_litret || dif.is_ret);
    take_rotl = idle && dif.is_rotl;
    rot       = rotl(i_file_rdata, i_carry); // see RQ8
  end

  // ---------------------------------------------------------------
  // return sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cyc_next   = cyc_reg;
    pc_next    = pc_reg;
    pcl_next   = 1'b0;
    pop_next   = 1'b0;
    busy_next  = 1'b0;
    unique case (state_reg)
      rre_pkg::ST_IDLE: begin
        if (take_ret) begin
          // flags never written on either return, see RQ1 see RQ4
          pc_next    = i_stack_top_entry; // see RQ2 see RQ4
          pcl_next   = 1'b1;
          pop_next   = 1'b1;
          busy_next  = 1'b1;
          cyc_next   = 2'h1;
          state_next = rre_pkg::ST_FLUSH;
        end
      end
      rre_pkg::ST_FLUSH: begin
        // second cycle discards the prefetched word, see RQ3 see RQ5
        cyc_next  = cyc_reg + 2'h1;
        busy_next = (cyc_reg + 2'h1) < rre_pkg::RET_CYCLES;
        if (!busy_next) begin
          state_next = rre_pkg::ST_IDLE;
        end else begin
          state_next = rre_pkg::ST_HOLD;
        end
      end
      rre_pkg::ST_HOLD: begin
        state_next = rre_pkg::ST_IDLE;
      end
      default: begin
        state_next = rre_pkg::ST_IDLE;
      end
    endcase
  end

  // sync reset drops every strobe together with the state
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_reg <= rre_pkg::ST_IDLE;
      cyc_reg   <= 2'h0;
      pc_reg    <= rre_pkg::PC_RST;
      pcl_reg   <= 1'b0;
      pop_reg   <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cyc_reg   <= cyc_next;
      pc_reg    <= pc_next;
      pcl_reg   <= pcl_next;
      pop_reg   <= pop_next;
      busy_reg  <= busy_next;
    end
  end

  // ---------------------------------------------------------------
  // accumulator and carry
  // ---------------------------------------------------------------
  // only the rotate may touch carry; both returns leave it alone
  always_comb begin
    w_next    = w_reg;
    w_we_next = 1'b0;
    c_next    = c_reg;
    c_we_next = 1'b0;
    if (take_ret && dif.is_litret) begin
      w_next    = dif.literal; // see RQ1
      w_we_next = 1'b1;
    end else if (take_rotl) begin
      c_next    = rot[rre_pkg::DATA_W]; // see RQ6 see RQ8
      c_we_next = 1'b1;
      if (!dif.dest_file) begin
        w_next    = rot[7:0]; // see RQ7
        w_we_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      w_reg    <= rre_pkg::W_RST;
      w_we_reg <= 1'b0;
      c_reg    <= 1'b0;
      c_we_reg <= 1'b0;
    end else begin
      w_reg    <= w_next;
      w_we_reg <= w_we_next;
      c_reg    <= c_next;
      c_we_reg <= c_we_next;
    end
  end

  // ---------------------------------------------------------------
  // file register write port
  // ---------------------------------------------------------------
  always_comb begin
    fa_next  = fa_reg;
    fd_next  = fd_reg;
    fwe_next = 1'b0;
    if (take_rotl && dif.dest_file) begin
      fa_next  = dif.faddr; // see RQ7
      fd_next  = rot[7:0];
      fwe_next = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      fa_reg  <= 7'h00;
      fd_reg  <= 8'h00;
      fwe_reg <= 1'b0;
    end else begin
      fa_reg  <= fa_next;
      fd_reg  <= fd_next;
      fwe_reg <= fwe_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // all straight from flops so the core never sees decode glitches
  assign o_w          = w_reg;
  assign o_w_we       = w_we_reg;
  assign o_carry      = c_reg;
  assign o_carry_we   = c_we_reg;
  assign o_pc         = pc_reg;
  assign o_pc_load    = pcl_reg;
  assign o_stack_pop  = pop_reg;
  assign o_file_addr  = fa_reg;
  assign o_file_wdata = fd_reg;
  assign o_file_we    = fwe_reg;
  assign o_busy       = busy_reg;
endmodule : rre_exec

// ===== rre_asserts.sv
`timescale 1ns/1ps
module rre_asserts (
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  // inputs
  input wire logic        i_insn_valid,
  input wire logic        i_carry,
  input wire logic [13:0] i_insn,
  input wire logic [12:0] i_stack_top_entry,
  input wire logic [7:0]  i_file_rdata,
  // outputs
  input wire logic        o_w_we,
  input wire logic        o_carry,
  input wire logic        o_carry_we,
  input wire logic        o_pc_load,
  input wire logic        o_stack_pop,
  input wire logic        o_file_we,
  input wire logic        o_busy,
  input wire logic [7:0]  o_w,
  input wire logic [7:0]  o_file_wdata,
  input wire logic [12:0] o_pc,
  input wire logic [6:0]  o_file_addr
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // issues during busy are dropped, so they never count as taken
  wire logic       tk  = i_insn_valid && !o_busy;
  wire logic       lr  = tk && (i_insn & rre_pkg::LITRET_MASK) == rre_pkg::LITRET_CODE;
  wire logic       rt  = tk && i_insn == rre_pkg::RET_CODE;
  wire logic       rl  = tk && (i_insn & rre_pkg::ROTL_MASK) == rre_pkg::ROTL_CODE;
  wire logic [7:0] rot = {i_file_rdata[6:0], i_carry};
  sequence s_redirect;
    o_busy && o_pc_load && o_stack_pop ##1 !o_busy && !o_pc_load;
  endsequence
  a_litret_acc: assert property (lr |=> o_w_we && o_w == $past(i_insn[7:0]))
    else $error("literal not in acc");
  a_ret_flags: assert property (lr || rt |=> !o_carry_we)
    else $error("flag written on return");
  a_ret_pc: assert property (lr || rt |=> o_pc == $past(i_stack_top_entry))
    else $error("pc not from stack");
  a_ret_two: assert property (lr || rt |=> s_redirect)
    else $error("return not two cycles");
  a_plain_no_acc: assert property (rt |=> !o_w_we)
    else $error("plain return wrote acc");
  a_rotl_carry: assert property (rl |=> o_carry_we && o_carry == $past(i_file_rdata[7]))
    else $error("rotate carry wrong");
  a_rotl_acc: assert property (rl && !i_insn[7] |=> o_w_we && !o_file_we && o_w == $past(rot))
    else $error("rotate to acc wrong");
  a_rotl_file: assert property (rl && i_insn[7] |=> o_file_we && !o_w_we && o_file_wdata == $past(rot))
    else $error("rotate to file wrong");
  a_rotl_one: assert property (rl |=> !o_busy && !o_pc_load && !o_stack_pop)
    else $error("rotate not one cycle");
  a_busy_drop: assert property (i_insn_valid && o_busy |=>
    !o_w_we && !o_carry_we && !o_file_we && !o_pc_load && !o_stack_pop)
    else $error("issue taken while busy");
endmodule : rre_asserts

// ===== rre_exec_test.sv
`timescale 1ns/1ps
module rre_exec_test;
  logic        i_clock = 0, i_rst_n = 0, i_insn_valid = 0, i_carry = 0;
  logic [13:0] i_insn = 14'h0000;
  logic [12:0] i_stack_top_entry = 13'h0000;
  logic [7:0]  i_file_rdata = 8'h00, i_w = 8'h5a;
  logic        o_w_we, o_carry, o_carry_we, o_pc_load, o_stack_pop, o_file_we, o_busy;
  logic [7:0]  o_w, o_file_wdata;
  logic [12:0] o_pc;
  logic [6:0]  o_file_addr;
  int          bad_count = 0, n_compared = 0, cyc = 0;
  always #5 i_clock = ~i_clock;
  rre_exec dut (
    .i_clock           (i_clock),
    .i_rst_n           (i_rst_n),
    .i_insn            (i_insn),
    .i_insn_valid      (i_insn_valid),
    .i_stack_top_entry (i_stack_top_entry),
    .i_file_rdata      (i_file_rdata),
    .i_w               (i_w),
    .i_carry           (i_carry),
    .o_w               (o_w),
    .o_w_we            (o_w_we),
    .o_carry           (o_carry),
    .o_carry_we        (o_carry_we),
    .o_pc              (o_pc),
    .o_pc_load         (o_pc_load),
    .o_stack_pop       (o_stack_pop),
    .o_file_addr       (o_file_addr),
    .o_file_wdata      (o_file_wdata),
    .o_file_we         (o_file_we),
    .o_busy            (o_busy)
  );
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  task automatic chk(input bit ok, input string m);
    n_compared++;
    if (!ok) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chk
  // one-cycle issue; returns in the answer cycle
  task automatic issue(input logic [13:0] ins, input logic [12:0] top, input logic [7:0] rd, input logic c);
    @(posedge i_clock);
    i_insn <= ins;
    i_insn_valid <= 1'b1;
    i_stack_top_entry <= top;
    i_file_rdata <= rd;
    i_carry <= c;
    @(posedge i_clock);
    i_insn_valid <= 1'b0;
    #1;
  endtask : issue
  task automatic t_return(input logic [13:0] ins, input logic [12:0] top, input bit lit);
    issue(ins, top, 8'hff, 1'b1);
    chk(o_pc === top && o_pc_load === 1'b1 && o_stack_pop === 1'b1, "pc");
    chk(o_w_we === lit && (!lit || o_w === ins[7:0]) && o_carry_we === 1'b0, "acc");
    chk(o_busy === 1'b1, "busy");
    @(posedge i_clock);
    #1;
    chk(o_busy === 1'b0 && o_pc_load === 1'b0 && o_w_we === 1'b0, "length");
    $display("return test done");
  endtask : t_return
  task automatic t_rotate(input bit d, input logic [6:0] f, input logic [7:0] v, input logic c);
    logic [7:0] r;
    issue(rre_pkg::ROTL_CODE | {6'h00, d, f}, 13'h0000, v, c);
    r = {v[6:0], c};
    chk(o_carry_we === 1'b1 && o_carry === v[7], "carry");
    chk(d ? (o_file_we === 1'b1 && o_file_addr === f && o_file_wdata === r && o_w_we === 1'b0)
          : (o_w_we === 1'b1 && o_w === r && o_file_we === 1'b0), "dest");
    chk(o_busy === 1'b0 && o_pc_load === 1'b0, "cycles");
    $display("rotate test done");
  endtask : t_rotate
  // a rotate offered in the flush cycle must be ignored
  task automatic t_refused();
    @(posedge i_clock);
    i_insn            <= 14'h3455;
    i_insn_valid      <= 1'b1;
    i_stack_top_entry <= 13'h0042;
    @(posedge i_clock);
    i_insn            <= rre_pkg::ROTL_CODE | 14'h0011;
    i_file_rdata      <= 8'h0f;
    #1;
    chk(o_busy === 1'b1 && o_w_we === 1'b1 && o_w === 8'h55 && o_pc === 13'h0042, "litret");
    @(posedge i_clock);
    i_insn_valid <= 1'b0;
    #1;
    chk(o_busy === 1'b0 && o_w_we === 1'b0 && o_carry_we === 1'b0 && o_file_we === 1'b0
        && o_w === 8'h55, "refused");
    $display("refused issue test done");
  endtask : t_refused
  // mid-run reset: every output back to its reset value
  task automatic t_reset();
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    @(posedge i_clock);
    i_rst_n <= 1'b1;
    #1;
    chk(o_w === rre_pkg::W_RST && o_pc === rre_pkg::PC_RST && o_carry === 1'b0, "reset data");
    chk(o_file_addr === 7'h00 && o_file_wdata === 8'h00, "reset file");
    chk({o_w_we, o_carry_we, o_pc_load, o_stack_pop, o_file_we, o_busy} === 6'h00, "reset strobes");
    $display("reset test done");
  endtask : t_reset
  initial begin
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_return(14'h3400, 13'h1fff, 1'b1);
    t_return(14'h37ff, 13'h0001, 1'b1);
    t_return(rre_pkg::RET_CODE, 13'h0abc, 1'b0);
    t_rotate(1'b0, 7'h00, 8'he6, 1'b0);
    t_rotate(1'b1, 7'h7f, 8'h01, 1'b1);
    t_rotate(1'b0, 7'h55, 8'h80, 1'b1);
    t_refused();
    t_reset();
    t_return(14'h34c3, 13'h1234, 1'b1);
    summarize();
  end
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      bad_count++;
      summarize();
    end
  end
endmodule : rre_exec_test
bind rre_exec rre_asserts u_chk (
  .i_clock           (i_clock),
  .i_rst_n           (i_rst_n),
  .i_insn_valid      (i_insn_valid),
  .i_carry           (i_carry),
  .i_insn            (i_insn),
  .i_stack_top_entry (i_stack_top_entry),
  .i_file_rdata      (i_file_rdata),
  .o_w_we            (o_w_we),
  .o_carry           (o_carry),
  .o_carry_we        (o_carry_we),
  .o_pc_load         (o_pc_load),
  .o_stack_pop       (o_stack_pop),
  .o_file_we         (o_file_we),
  .o_busy            (o_busy),
  .o_w               (o_w),
  .o_file_wdata      (o_file_wdata),
  .o_pc              (o_pc),
  .o_file_addr       (o_file_addr)
);
